// *** hdl/servo_status_pkg.sv ***
// Shared constants for the servo status output block
package servo_status_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MOTION_THR = 8'h04;
	localparam logic [7:0] OFS_SPEED_BAND = 8'h08;
	localparam logic [7:0] OFS_DONE_THR = 8'h0c;
	localparam logic [7:0] OFS_GEAR = 8'h10;
	localparam logic [7:0] OFS_DIVIDER = 8'h14;
	localparam logic [7:0] OFS_ALLOC = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_INT_STAT = 8'h20;
	localparam logic [7:0] OFS_INT_MASK = 8'h24;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_HALLLESS_BIT = 2;
	localparam logic [1:0] MODE_SPEED = 2'h0;
	localparam logic [1:0] MODE_POSITION = 2'h1;
	localparam logic [1:0] MODE_FORCE = 2'h2;
	localparam int GEAR_DEN_LSB = 16;
	localparam int ALLOC_FIELD_W = 4;
	localparam int NUM_TERMS = 3;
	localparam int NUM_EVENTS = 4;
	localparam int EV_FAULT = 0;
	localparam int EV_READY = 1;
	localparam int EV_MOTION = 2;
	localparam int EV_POSITION_DONE_OUT = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] MOTION_THR_RESET = 16'h0014;
	localparam logic [15:0] SPEED_BAND_RESET = 16'h000a;
	localparam logic [31:0] DONE_THR_RESET = 32'h0000_0007;
	localparam logic [31:0] GEAR_RESET = 32'h0001_0001;
	localparam logic [15:0] DIVIDER_RESET = 16'h0001;
	localparam logic [11:0] ALLOC_RESET = 12'h321;

	// ----------------------------------------------------------------
	// Terminal source selection codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_MOTION = 4'h1;
	localparam logic [3:0] SRC_READY = 4'h2;
	localparam logic [3:0] SRC_POSITION_DONE_OUT = 4'h3;
	localparam logic [3:0] SRC_CUR_LIMIT = 4'h4;
	localparam logic [3:0] SRC_SPD_LIMIT = 4'h5;
	localparam logic [3:0] SRC_BRAKE = 4'h6;
	localparam logic [3:0] SRC_WARN = 4'h7;
	localparam logic [3:0] SRC_NEAR = 4'h8;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [15:0] DIV_ONE = 16'h0001;
endpackage : servo_status_pkg

// *** hdl/quad_divider.sv ***
// Divided quadrature encoder output with zero-point pulse
`timescale 1ns/1ps
module quad_divider
	import servo_status_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enc_step,
	input wire logic enc_dir,
	input wire logic enc_index,
	input wire logic [15:0] ratio,
	output logic enc_phase_a_out,
	output logic enc_phase_a_n_out,
	output logic enc_phase_b_out,
	output logic enc_phase_b_n_out,
	output logic enc_zero_pulse_out,
	output logic enc_zero_pulse_n_out
);
	logic [15:0] step_cnt;
	logic [1:0] phase;
	logic [1:0] next_phase;
	logic [15:0] limit;
	logic wrap;

	// Ratio zero acts as one so the outputs never freeze
	assign limit = (ratio == 16'h0000) ? DIV_ONE : ratio;
	assign wrap = enc_step && (step_cnt >= limit - DIV_ONE);
	assign next_phase = !wrap ? phase : (enc_dir ? phase - 2'h1 : phase + 2'h1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_cnt <= 16'h0000;
		end else if (wrap) begin
			step_cnt <= 16'h0000;
		end else if (enc_step) begin
			step_cnt <= step_cnt + DIV_ONE;
		end
	end

	// Gray sequence: one phase edge per divided step [R05]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= 2'h0;
			enc_phase_a_out <= 1'b0;
			enc_phase_a_n_out <= 1'b1;
			enc_phase_b_out <= 1'b0;
			enc_phase_b_n_out <= 1'b1;
		end else begin
			phase <= next_phase;
			enc_phase_a_out <= next_phase[1];
			enc_phase_a_n_out <= !next_phase[1];
			enc_phase_b_out <= next_phase[1] ^ next_phase[0];
			enc_phase_b_n_out <= !(next_phase[1] ^ next_phase[0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enc_zero_pulse_out <= 1'b0;
			enc_zero_pulse_n_out <= 1'b1;
		end else begin
			enc_zero_pulse_out <= enc_index; // [R06]
			enc_zero_pulse_n_out <= !enc_index; // [R06]
		end
	end

	a_pair_complement: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
		(enc_phase_a_out != enc_phase_a_n_out) && (enc_phase_b_out != enc_phase_b_n_out))
		else $error("quadrature pair not complementary");
	a_zero_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
		enc_index |=> enc_zero_pulse_out && !enc_zero_pulse_n_out)
		else $error("zero pulse did not follow index");
	a_one_edge_only: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
		!($changed(enc_phase_a_out) && $changed(enc_phase_b_out)))
		else $error("both phases changed in one cycle");
endmodule : quad_divider

// *** hdl/servo_status_out.sv ***
// Servo status outputs, terminal allocation and AHB-Lite register file
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Fault output is off while an error is present, on otherwise.
// [R02] Motion detect is on while speed magnitude exceeds the programmed threshold.
// [R03] Ready needs control and main power and no active fault.
// [R04] Without Hall sensors, ready also waits for polarity detection done.
// [R05] Encoder position leaves as divided A/B quadrature, each a complementary pair.
// [R06] Zero-point pulse leaves on its own complementary pair.
// [R07] Active fault shown as a 3-bit code on three outputs.
// [R08] Speed mode: match on while speed lies within band of reference.
// [R09] Position mode: done on once position error reaches completion value.
// [R10] Completion value is in reference units, scaled through the electronic gear.
// [R11] Speed match and position done share one terminal, chosen by mode.
// [R12] Software assigns each terminal its source signal.
// [R13] Output high means conducting, meaning asserted; all updates on hclk.
module servo_status_out
	import servo_status_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic control_power_pin,
	input wire logic main_power_pin,
	input wire logic fault_active,
	input wire logic [2:0] fault_code,
	input wire logic polarity_done,
	input wire logic signed [15:0] motor_speed,
	input wire logic signed [15:0] ref_speed,
	input wire logic signed [31:0] pos_error,
	input wire logic current_limit_flag,
	input wire logic speed_limit_flag,
	input wire logic brake_request,
	input wire logic warning_active,
	input wire logic near_position,
	input wire logic enc_step,
	input wire logic enc_dir,
	input wire logic enc_index,
	output logic servo_fault_out,
	output logic [2:0] status_term,
	output logic fault_code_bit0,
	output logic fault_code_bit1,
	output logic fault_code_bit2,
	output logic enc_phase_a_out,
	output logic enc_phase_a_n_out,
	output logic enc_phase_b_out,
	output logic enc_phase_b_n_out,
	output logic enc_zero_pulse_out,
	output logic enc_zero_pulse_n_out,
	output logic irq
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [15:0] motion_thr;
	logic [15:0] speed_band;
	logic [31:0] done_thr;
	logic [31:0] gear;
	logic [15:0] divider;
	logic [11:0] alloc;
	logic [NUM_EVENTS-1:0] int_stat;
	logic [NUM_EVENTS-1:0] int_mask;

	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] next_rdata;
	logic addr_ok;

	// ----------------------------------------------------------------
	// Status detection
	// ----------------------------------------------------------------
	logic ctl_pwr_s1, ctl_pwr_s2, main_pwr_s1, main_pwr_s2;
	logic motion_detect_out;
	logic servo_ready_out;
	logic speed_match_out;
	logic position_done_out;
	logic position_done_out_term;
	logic brake_control_out;
	logic [15:0] speed_mag;
	logic [16:0] speed_diff;
	logic [16:0] diff_mag;
	logic [31:0] err_mag;
	logic [47:0] err_scaled;
	logic [47:0] thr_scaled;
	logic [1:0] mode;
	logic hall_less;
	logic [NUM_EVENTS-1:0] ev_level;
	logic [NUM_EVENTS-1:0] ev_prev;
	logic [NUM_EVENTS-1:0] ev_rise;
	logic [NUM_EVENTS-1:0] w1c;

	assign mode = ctrl[CTRL_MODE_LSB +: 2];
	assign hall_less = ctrl[CTRL_HALLLESS_BIT];
	assign speed_mag = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
	assign speed_diff = {motor_speed[15], motor_speed} - {ref_speed[15], ref_speed};
	assign diff_mag = speed_diff[16] ? 17'(-speed_diff) : speed_diff;
	assign err_mag = pos_error[31] ? 32'(-pos_error) : pos_error;
	// Error counts times gear denominator against threshold times numerator,
	// so the threshold stays in reference units without a divider [R10]
	assign err_scaled = err_mag * gear[GEAR_DEN_LSB +: 16];
	assign thr_scaled = done_thr * gear[15:0];

	// Power inputs are asynchronous pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_pwr_s1 <= 1'b0;
			ctl_pwr_s2 <= 1'b0;
			main_pwr_s1 <= 1'b0;
			main_pwr_s2 <= 1'b0;
		end else begin
			ctl_pwr_s1 <= control_power_pin;
			ctl_pwr_s2 <= ctl_pwr_s1;
			main_pwr_s1 <= main_power_pin;
			main_pwr_s2 <= main_pwr_s1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			servo_fault_out <= 1'b0;
			fault_code_bit0 <= 1'b0;
			fault_code_bit1 <= 1'b0;
			fault_code_bit2 <= 1'b0;
		end else begin
			servo_fault_out <= !fault_active; // [R01] [R13]
			fault_code_bit0 <= fault_code[0]; // [R07]
			fault_code_bit1 <= fault_code[1]; // [R07]
			fault_code_bit2 <= fault_code[2]; // [R07]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			motion_detect_out <= 1'b0;
			servo_ready_out <= 1'b0;
			speed_match_out <= 1'b0;
			position_done_out <= 1'b0;
			brake_control_out <= 1'b0;
		end else begin
			motion_detect_out <= speed_mag > motion_thr; // [R02]
			servo_ready_out <= ctl_pwr_s2 && main_pwr_s2 && !fault_active // [R03]
				&& (!hall_less || polarity_done); // [R04]
			speed_match_out <= (mode == MODE_SPEED) && (diff_mag <= {1'b0, speed_band}); // [R08]
			position_done_out <= (mode == MODE_POSITION) && (err_scaled <= thr_scaled); // [R09]
			brake_control_out <= brake_request;
		end
	end

	// One terminal for both, chosen by mode [R11]
	assign position_done_out_term = (mode == MODE_POSITION) ? position_done_out : speed_match_out;

	// ----------------------------------------------------------------
	// Terminal allocation
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TERMS; gi++) begin : g_term
			logic [3:0] sel;
			assign sel = alloc[gi*ALLOC_FIELD_W +: ALLOC_FIELD_W];
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					status_term[gi] <= 1'b0;
				end else begin
					case (sel) // [R12]
						SRC_MOTION: status_term[gi] <= motion_detect_out;
						SRC_READY: status_term[gi] <= servo_ready_out;
						SRC_POSITION_DONE_OUT: status_term[gi] <= position_done_out_term;
						SRC_CUR_LIMIT: status_term[gi] <= current_limit_flag;
						SRC_SPD_LIMIT: status_term[gi] <= speed_limit_flag;
						SRC_BRAKE: status_term[gi] <= brake_control_out;
						SRC_WARN: status_term[gi] <= warning_active;
						SRC_NEAR: status_term[gi] <= near_position;
						default: status_term[gi] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	quad_divider u_quad (
		.hclk(hclk),
		.hresetn(hresetn),
		.enc_step(enc_step),
		.enc_dir(enc_dir),
		.enc_index(enc_index),
		.ratio(divider),
		.enc_phase_a_out(enc_phase_a_out),
		.enc_phase_a_n_out(enc_phase_a_n_out),
		.enc_phase_b_out(enc_phase_b_out),
		.enc_phase_b_n_out(enc_phase_b_n_out),
		.enc_zero_pulse_out(enc_zero_pulse_out),
		.enc_zero_pulse_n_out(enc_zero_pulse_n_out)
	);

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign ev_level = {position_done_out | speed_match_out, motion_detect_out,
		servo_ready_out, fault_active};
	assign ev_rise = ev_level & ~ev_prev;
	assign w1c = (wr_pend && wr_addr == OFS_INT_STAT) ? hwdata[NUM_EVENTS-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_prev <= '0;
			int_stat <= '0;
			irq <= 1'b0;
		end else begin
			ev_prev <= ev_level;
			// A new event in the clearing cycle survives
			int_stat <= (int_stat & ~w1c) | ev_rise;
			irq <= |(((int_stat & ~w1c) | ev_rise) & int_mask);
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addr_ok) begin
			case (haddr[7:0])
				OFS_CTRL: next_rdata = ctrl;
				OFS_MOTION_THR: next_rdata = {16'h0000, motion_thr};
				OFS_SPEED_BAND: next_rdata = {16'h0000, speed_band};
				OFS_DONE_THR: next_rdata = done_thr;
				OFS_GEAR: next_rdata = gear;
				OFS_DIVIDER: next_rdata = {16'h0000, divider};
				OFS_ALLOC: next_rdata = {20'h00000, alloc};
				OFS_STATUS: next_rdata = {20'h00000, status_term, servo_fault_out,
					fault_code_bit2, fault_code_bit1, fault_code_bit0,
					position_done_out, speed_match_out, servo_ready_out,
					motion_detect_out, brake_control_out};
				OFS_INT_STAT: next_rdata = {28'h0000000, int_stat};
				OFS_INT_MASK: next_rdata = {28'h0000000, int_mask};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite && addr_ok;
			wr_addr <= haddr[7:0];
			if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RESET;
			motion_thr <= MOTION_THR_RESET;
			speed_band <= SPEED_BAND_RESET;
			done_thr <= DONE_THR_RESET;
			gear <= GEAR_RESET;
			divider <= DIVIDER_RESET;
			alloc <= ALLOC_RESET;
			int_mask <= '0;
		end else if (wr_pend) begin
			case (wr_addr)
				OFS_CTRL: ctrl <= hwdata;
				OFS_MOTION_THR: motion_thr <= hwdata[15:0];
				OFS_SPEED_BAND: speed_band <= hwdata[15:0];
				OFS_DONE_THR: done_thr <= hwdata;
				OFS_GEAR: gear <= hwdata;
				OFS_DIVIDER: divider <= hwdata[15:0];
				OFS_ALLOC: alloc <= hwdata[11:0]; // [R12]
				OFS_INT_MASK: int_mask <= hwdata[NUM_EVENTS-1:0];
				default: ctrl <= ctrl;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_fault_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
		fault_active |=> !servo_fault_out)
		else $error("fault output on during error");
	a_motion_thr: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
		##1 motion_detect_out == ($past(speed_mag) > $past(motion_thr)))
		else $error("motion detect disagrees with threshold");
	a_ready_power: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
		servo_ready_out |-> $past(ctl_pwr_s2) && $past(main_pwr_s2) && !$past(fault_active))
		else $error("ready without power or with fault");
	a_ready_polarity: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
		$past(hall_less) && !$past(polarity_done) |-> !servo_ready_out)
		else $error("ready before polarity detection");
	a_code_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
		##1 {fault_code_bit2, fault_code_bit1, fault_code_bit0} == $past(fault_code))
		else $error("fault code not presented");
	a_match_band: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
		speed_match_out |-> $past(mode) == MODE_SPEED && $past(diff_mag) <= $past(speed_band))
		else $error("speed match outside band");
	a_done_thr: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
		position_done_out |-> $past(mode) == MODE_POSITION)
		else $error("position done outside position mode");
	a_done_scaled: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
		$past(mode) == MODE_POSITION |-> position_done_out == ($past(err_scaled) <= $past(thr_scaled)))
		else $error("completion not in reference units");
	a_position_done_out_select: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
		alloc[ALLOC_FIELD_W-1:0] == SRC_POSITION_DONE_OUT && $stable(alloc) |=> status_term[0] == $past(position_done_out_term))
		else $error("coincidence terminal wrong source");
	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
		##1 irq == |(int_stat & $past(int_mask)))
		else $error("interrupt level wrong");

	c_ready_up: cover property (@(posedge hclk) disable iff (!hresetn) $rose(servo_ready_out));
	c_done_up: cover property (@(posedge hclk) disable iff (!hresetn) $rose(position_done_out));
	c_irq_up: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule : servo_status_out

// *** testbench/host_ctrl_model.sv ***
// Host controller model: line receivers, quadrature counter and zero mark counter
`timescale 1ns/1ps
module host_ctrl_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enc_phase_a_out,
	input wire logic enc_phase_a_n_out,
	input wire logic enc_phase_b_out,
	input wire logic enc_phase_b_n_out,
	input wire logic enc_zero_pulse_out,
	input wire logic enc_zero_pulse_n_out,
	output logic [31:0] pos_count,
	output logic pair_bad,
	output logic [31:0] zero_count
);
	// ----------------
	// Quadrature decode
	// ----------------
	logic [1:0] ph;
	logic [1:0] last_ph;
	logic [1:0] diff;
	logic last_z;
	// Up order 00,01,11,10 on {a,b} maps to states 0..3: phase b leads going up
	assign ph = {enc_phase_a_out, enc_phase_a_out ^ enc_phase_b_out};
	assign diff = ph - last_ph;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_count <= 32'h0;
			last_ph <= 2'h0;
			pair_bad <= 1'b0;
			zero_count <= 32'h0;
			last_z <= 1'b0;
		end else begin
			if (diff == 2'd1) begin
				pos_count <= pos_count + 32'h1;
			end else if (diff == 2'd3) begin
				pos_count <= pos_count - 32'h1;
			end
			last_ph <= ph;
			// A two-state jump cannot be decoded by a real receiver, so it counts as broken
			if ((enc_phase_a_out ^ enc_phase_a_n_out) !== 1'b1
					|| (enc_phase_b_out ^ enc_phase_b_n_out) !== 1'b1
					|| (enc_zero_pulse_out ^ enc_zero_pulse_n_out) !== 1'b1
					|| diff == 2'd2) begin
				pair_bad <= 1'b1;
			end
			if (enc_zero_pulse_out && !last_z) begin
				zero_count <= zero_count + 32'h1;
			end
			last_z <= enc_zero_pulse_out;
		end
	end
endmodule : host_ctrl_model

// *** testbench/tb_servo_status_output_logic.sv ***
// Self-checking bench for the servo status output block
`timescale 1ns/1ps
module tb_servo_status_output_logic;
	import servo_status_pkg::*;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp, irq, polarity_done;
	logic control_power_pin, main_power_pin, fault_active, servo_fault_out;
	logic current_limit_flag, speed_limit_flag, brake_request, warning_active, near_position;
	logic enc_step, enc_dir, enc_index, fault_code_bit0, fault_code_bit1, fault_code_bit2;
	logic enc_phase_a_out, enc_phase_a_n_out, enc_phase_b_out, enc_phase_b_n_out;
	logic enc_zero_pulse_out, enc_zero_pulse_n_out, pair_bad;
	logic [1:0] htrans;
	logic [2:0] hsize, fault_code, status_term;
	logic [31:0] haddr, hwdata, hrdata, rd, cnt0, pos_count, zero_count;
	logic signed [15:0] motor_speed, ref_speed;
	logic signed [31:0] pos_error;
	logic [7:0] offs [8] = '{OFS_CTRL, OFS_MOTION_THR, OFS_SPEED_BAND, OFS_DONE_THR,
		OFS_GEAR, OFS_DIVIDER, OFS_ALLOC, OFS_INT_MASK};
	logic [31:0] rst [8] = '{CTRL_RESET, 32'(MOTION_THR_RESET), 32'(SPEED_BAND_RESET),
		DONE_THR_RESET, GEAR_RESET, 32'(DIVIDER_RESET), 32'(ALLOC_RESET), 32'h0};
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int seed;
	always #5 hclk = ~hclk;

	servo_status_out uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .control_power_pin, .main_power_pin,
		.fault_active, .fault_code, .polarity_done, .motor_speed, .ref_speed, .pos_error,
		.current_limit_flag, .speed_limit_flag, .brake_request, .warning_active,
		.near_position, .enc_step, .enc_dir, .enc_index, .servo_fault_out, .status_term,
		.fault_code_bit0, .fault_code_bit1, .fault_code_bit2, .enc_phase_a_out,
		.enc_phase_a_n_out, .enc_phase_b_out, .enc_phase_b_n_out, .enc_zero_pulse_out,
		.enc_zero_pulse_n_out, .irq);
	host_ctrl_model host (.hclk, .hresetn, .enc_phase_a_out, .enc_phase_a_n_out,
		.enc_phase_b_out, .enc_phase_b_n_out, .enc_zero_pulse_out, .enc_zero_pulse_n_out,
		.pos_count, .pair_bad, .zero_count);

	// ----------------
	// Tasks
	// ----------------
	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// Single transfer; waits on hready rather than assuming zero wait states
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, {24'h0, a}, d, rd);
	endtask : wr

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : settle

	task automatic steps(input int n, input logic dn);
		repeat (n) begin
			@(posedge hclk);
			enc_step <= 1'b1;
			enc_dir <= dn;
			@(posedge hclk);
			enc_step <= 1'b0;
		end
	endtask : steps

	function automatic logic exp_term(input logic [3:0] code, input logic [4:0] p);
		if (code >= SRC_CUR_LIMIT && code <= SRC_NEAR) begin
			return p[3'(code - SRC_CUR_LIMIT)];
		end
		return code != SRC_NONE && code < SRC_CUR_LIMIT;
	endfunction : exp_term

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			tally_and_finish();
		end
	end

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		int k;
		logic signed [15:0] s;
		logic signed [15:0] tab [6];
		logic signed [31:0] errs [6];
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, fault_active, fault_code} = '0;
		{control_power_pin, main_power_pin, polarity_done, enc_step, enc_dir, enc_index} = '0;
		{current_limit_flag, speed_limit_flag, brake_request, warning_active} = '0;
		near_position = 1'b0;
		hsize = 3'h2;
		motor_speed = 16'sd0;
		ref_speed = 16'sd0;
		pos_error = 32'sd0;
		seed = $urandom(92580);
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (offs[i]) begin
			ahb(1'b0, {24'h0, offs[i]}, 32'h0, rd);
			check(rd, rst[i], "reset value");
		end
		ahb(1'b1, 32'h100, $urandom(), rd);
		ahb(1'b0, 32'h100, 32'h0, rd);
		check(rd, 32'h0, "unmapped read");
		check(32'(hresp), 32'h0, "response okay");
		repeat (8) begin
			@(posedge hclk);
			fault_active <= 1'b1;
			fault_code <= 3'($urandom_range(7));
			settle(2);
			check({29'h0, fault_code_bit2, fault_code_bit1, fault_code_bit0}, 32'(fault_code), "code");
			check(32'(servo_fault_out), 32'h0, "fault out");
		end
		@(posedge hclk);
		fault_active <= 1'b0;
		settle(2);
		check(32'(servo_fault_out), 32'h1, "fault clear");
		@(posedge hclk);
		control_power_pin <= 1'b1;
		settle(6);
		check(32'(status_term[1]), 32'h0, "ready, main off");
		@(posedge hclk);
		main_power_pin <= 1'b1;
		settle(6);
		check(32'(status_term[1]), 32'h1, "ready");
		// A set mask bit lets its event through to irq
		wr(OFS_INT_STAT, 32'hf);
		wr(OFS_INT_MASK, 32'h1);
		@(posedge hclk);
		fault_active <= 1'b1;
		settle(4);
		check(32'(status_term[1]), 32'h0, "ready with fault");
		check(32'(irq), 32'h1, "irq raised");
		ahb(1'b0, 32'(OFS_INT_STAT), 32'h0, rd);
		check(rd & 32'h1, 32'h1, "fault event");
		wr(OFS_INT_MASK, 32'h0);
		settle(2);
		check(32'(irq), 32'h0, "irq masked");
		wr(OFS_INT_MASK, 32'h1);
		wr(OFS_INT_STAT, 32'h1);
		settle(2);
		check(32'(irq), 32'h0, "irq cleared");
		@(posedge hclk);
		fault_active <= 1'b0;
		wr(OFS_CTRL, 32'h1 << CTRL_HALLLESS_BIT);
		settle(4);
		check(32'(status_term[1]), 32'h0, "ready before polarity");
		@(posedge hclk);
		polarity_done <= 1'b1;
		settle(4);
		check(32'(status_term[1]), 32'h1, "ready after polarity");
		tab = '{16'sd20, 16'sd21, -16'sd20, -16'sd21, 16'sd0, 16'sd300};
		for (k = 0; k < 10; k++) begin
			s = (k < 6) ? tab[k] : 16'(signed'($urandom_range(60)) - 30);
			@(posedge hclk);
			motor_speed <= s;
			settle(3);
			check(32'(status_term[0]), 32'(s > 16'sd20 || s < -16'sd20), "motion");
		end
		tab = '{-16'sd11, -16'sd10, 16'sd10, 16'sd11, 16'sd0, 16'sd500};
		foreach (tab[i]) begin
			s = 16'(signed'($urandom_range(2000)) - 1000);
			@(posedge hclk);
			ref_speed <= s;
			motor_speed <= s + tab[i];
			settle(3);
			check(32'(status_term[2]), 32'(tab[i] <= 10 && tab[i] >= -10), "match");
		end
		// Gear 3/2 with threshold 7 puts the edge at an error of 10
		wr(OFS_CTRL, 32'h4 | 32'(MODE_POSITION));
		wr(OFS_GEAR, 32'h0002_0003);
		errs = '{32'sd10, 32'sd11, -32'sd10, -32'sd11, 32'sd0, 32'sd1000};
		foreach (errs[i]) begin
			@(posedge hclk);
			motor_speed <= ref_speed;
			pos_error <= errs[i];
			settle(3);
			check(32'(status_term[2]), 32'(errs[i] <= 10 && errs[i] >= -10), "done");
		end
		wr(OFS_CTRL, 32'h4 | 32'(MODE_FORCE));
		settle(3);
		check(32'(status_term[2]), 32'h0, "force mode position_done_out");
		wr(OFS_CTRL, 32'h4 | 32'(MODE_SPEED));
		@(posedge hclk);
		motor_speed <= 16'sd100;
		ref_speed <= 16'sd100;
		for (k = 0; k < 9; k++) begin
			wr(OFS_ALLOC, {20'h0, 8'h32, 4'(k)});
			repeat (2) begin
				@(posedge hclk);
				{near_position, warning_active, brake_request, speed_limit_flag,
					current_limit_flag} <= 5'($urandom());
				settle(3);
				check(32'(status_term[0]), 32'(exp_term(4'(k), {near_position, warning_active,
					brake_request, speed_limit_flag, current_limit_flag})), "alloc");
			end
		end
		wr(OFS_DIVIDER, 32'h2);
		k = $urandom_range(20, 1);
		cnt0 = pos_count;
		steps(2 * k, 1'b0);
		settle(4);
		check(pos_count - cnt0, 32'(k), "count up");
		k = $urandom_range(20, 1);
		cnt0 = pos_count;
		steps(2 * k, 1'b1);
		settle(4);
		check(pos_count - cnt0, 32'(-k), "count down");
		@(posedge hclk);
		enc_index <= 1'b1;
		@(posedge hclk);
		enc_index <= 1'b0;
		settle(3);
		check(zero_count, 32'h1, "zero pulse");
		check(32'(pair_bad), 32'h0, "pairs");
		tally_and_finish();
	end
endmodule : tb_servo_status_output_logic
